// ---- core/alf_cfg.svh ----
// Purpose: Register map, field positions and power-on values of the alert limit flag logic.
// Assumes: One 16-bit register word per pointer value.
// Notes: Definitions only; included by the package and the core module.
//
// What this block does
// - Channel 3 bus voltage reads as sign, 12-bit magnitude, low three bits zero.
// - Every single shunt conversion is compared against its channel critical limit.
// - Every averaged shunt result is compared against its channel warning limit.
// - Channel limits are 13-bit fields in bits 15:3, low bits zero, reset 7FF8; the sum limit uses 15:1, reset 7FFE.
// - The sum holds only single conversions of channels selected for summation.
// - The sum updates after each full pass; sign bit 15, value 14:1, bit 0 zero.
// - After each full pass the sum is compared against the sum limit.
// - Sum select bits include channels only; they change no channel measurement.
// - Warning latch bit off makes warning pin transparent; on makes it latched.
// - Critical latch bit off makes critical pin transparent; on makes it latched.
// - A critical limit exceeded asserts the critical pin and that channel's flag.
// - Sum above sum limit sets the sum flag and asserts the critical pin.
// - An averaged value above warning limit asserts warning pin and channel flag.
// - Reading the flag register clears the alert flags; writing leaves them unchanged.
// - The power good flag mirrors the power valid pin and clears with it.
// - The timing flag sets with its pin, powers up set, stays set until reset.
// - Conversion done sets when conversions finish; clears on config write or flag read.
// - Voltages, limits and sums are twos complement, top bit marks negative.
// - Power valid is reached only when all bus channels exceed the upper limit.
`ifndef ALF_CFG_SVH
`define ALF_CFG_SVH

// ----------------------------------------------------------------------------
// Register pointers
// ----------------------------------------------------------------------------
`define ALF_A_BUS3 8'h06
`define ALF_A_CRIT1 8'h07
`define ALF_A_WARN1 8'h08
`define ALF_A_CRIT2 8'h09
`define ALF_A_WARN2 8'h0A
`define ALF_A_CRIT3 8'h0B
`define ALF_A_WARN3 8'h0C
`define ALF_A_TOTAL 8'h0D
`define ALF_A_TLIM 8'h0E
`define ALF_A_MASK 8'h0F

// ----------------------------------------------------------------------------
// Field masks, positions and power-on values
// ----------------------------------------------------------------------------
`define ALF_LIM_MASK 16'hFFF8
`define ALF_SUM_MASK 16'hFFFE
`define ALF_LIM_POR 16'h7FF8
`define ALF_TLIM_POR 16'h7FFE
`define ALF_B_SEL1 14
`define ALF_B_SEL3 12
`define ALF_B_WLAT 11
`define ALF_B_CLAT 10
`define ALF_NCH 3

`endif

// ---- core/alf_pkg.sv ----
// Purpose: Types shared by the alert limit flag logic and its bench.
// Assumes: Three channels, channel code 0 to 2 meaning channels 1 to 3.
// Notes: Constants live in alf_cfg.svh.
`include "alf_cfg.svh"

package alf_pkg;

	// One conversion result handed over by the measurement engine.
	typedef struct packed {
		logic valid;
		logic [1:0] ch;
		logic [15:0] value;
	} alf_sample_t;

	// Entire state of the core; index 0 of each array is channel 1.
	typedef struct packed {
		logic [`ALF_NCH-1:0][15:0] bus;
		logic [`ALF_NCH-1:0][15:0] crit_lim;
		logic [`ALF_NCH-1:0][15:0] warn_lim;
		logic [15:0] total;
		logic [15:0] total_lim;
		logic [14:0] acc;
		logic [`ALF_NCH-1:0] sum_channel_select;
		logic warn_latch_on;
		logic critical_latch_on;
		logic [`ALF_NCH-1:0] critical_flags;
		logic sum_over_flag;
		logic [`ALF_NCH-1:0] warning_flags;
		logic timing_alert_flag;
		logic conversion_done_flag;
		logic [`ALF_NCH-1:0] crit_cond;
		logic sum_cond;
		logic [`ALF_NCH-1:0] warn_cond;
		logic crit_hold;
		logic warn_hold;
		logic [15:0] rdata;
		logic rvalid;
		logic crit_pin_n;
		logic warn_pin_n;
		logic pv_pin;
	} alf_state_t;

endpackage

// ---- core/alf_alert_limit_flag.sv ----
// Purpose: Limit compare, shunt sum and alert flag logic of a three-channel monitor.
// Assumes: Serial protocol decoded elsewhere into one-cycle register strobes.
// Notes: Alert pins are active low levels; power valid is active high.
`timescale 1ns/1ps
`include "alf_cfg.svh"

module alf_alert_limit_flag (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic soft_reset,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	input wire alf_pkg::alf_sample_t shunt_single,
	input wire alf_pkg::alf_sample_t shunt_avg,
	input wire alf_pkg::alf_sample_t bus_sample,
	input wire logic pass_done,
	input wire logic conv_done,
	input wire logic cfg_write_clear,
	input wire logic timing_alert_in,
	input wire logic [15:0] pv_upper_limit,
	input wire logic [15:0] pv_lower_limit,
	output logic crit_alert_n,
	output logic warn_alert_n,
	output logic power_valid_alert
);

	alf_pkg::alf_state_t st_r;
	alf_pkg::alf_state_t st_nxt;
	logic mask_rd;
	logic mask_wr;
	logic s_exc;
	logic a_exc;
	logic sum_exc;
	logic s_ok;
	logic a_ok;
	logic [14:0] acc_in;
	logic [`ALF_NCH-1:0] pv_above;
	logic [`ALF_NCH-1:0] pv_below;

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	// Both operands carry the same alignment, so a plain signed compare works.
	function automatic logic gt(input logic [15:0] a, input logic [15:0] b);
		return $signed(a) > $signed(b);
	endfunction

	function automatic alf_pkg::alf_state_t por_st();
		alf_pkg::alf_state_t s;
		s = '0;
		s.crit_lim = {`ALF_NCH{`ALF_LIM_POR}};
		s.warn_lim = {`ALF_NCH{`ALF_LIM_POR}};
		s.total_lim = `ALF_TLIM_POR;
		s.timing_alert_flag = 1'b1;
		s.crit_pin_n = 1'b1;
		s.warn_pin_n = 1'b1;
		return s;
	endfunction

	// ------------------------------------------------------------------------
	// Compare terms
	// ------------------------------------------------------------------------
	assign mask_rd = reg_rd && (reg_addr == `ALF_A_MASK);
	assign mask_wr = reg_wr && (reg_addr == `ALF_A_MASK);
	assign s_ok = shunt_single.valid && (shunt_single.ch < 2'(`ALF_NCH));
	assign a_ok = shunt_avg.valid && (shunt_avg.ch < 2'(`ALF_NCH));
	assign s_exc = gt(shunt_single.value & `ALF_LIM_MASK, st_r.crit_lim[shunt_single.ch]);
	assign a_exc = gt(shunt_avg.value & `ALF_LIM_MASK, st_r.warn_lim[shunt_avg.ch]);
	// Unselected channels add nothing, their measurements stay untouched.
	assign acc_in = (s_ok && st_r.sum_channel_select[shunt_single.ch]) ?
		st_r.acc + {{2{shunt_single.value[15]}}, shunt_single.value[15:3]} : st_r.acc;
	assign sum_exc = gt({acc_in, 1'b0}, st_r.total_lim);

	genvar gi;
	generate
		for (gi = 0; gi < `ALF_NCH; gi++) begin : g_pv
			assign pv_above[gi] = gt(st_r.bus[gi], pv_upper_limit);
			assign pv_below[gi] = gt(pv_lower_limit, st_r.bus[gi]);
		end
	endgenerate

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		logic crit_any;
		logic warn_any;
		crit_any = 1'b0;
		warn_any = 1'b0;
		st_nxt = st_r;
		st_nxt.rvalid = 1'b0;

		if (reg_wr) begin
			case (reg_addr)
				`ALF_A_CRIT1: st_nxt.crit_lim[0] = reg_wdata & `ALF_LIM_MASK;
				`ALF_A_WARN1: st_nxt.warn_lim[0] = reg_wdata & `ALF_LIM_MASK;
				`ALF_A_CRIT2: st_nxt.crit_lim[1] = reg_wdata & `ALF_LIM_MASK;
				`ALF_A_WARN2: st_nxt.warn_lim[1] = reg_wdata & `ALF_LIM_MASK;
				`ALF_A_CRIT3: st_nxt.crit_lim[2] = reg_wdata & `ALF_LIM_MASK;
				`ALF_A_WARN3: st_nxt.warn_lim[2] = reg_wdata & `ALF_LIM_MASK;
				`ALF_A_TLIM: st_nxt.total_lim = reg_wdata & `ALF_SUM_MASK;
				`ALF_A_MASK: begin
					// Only the control bits take the write; flags are left alone.
					st_nxt.sum_channel_select = {reg_wdata[`ALF_B_SEL3],
						reg_wdata[`ALF_B_SEL3+1], reg_wdata[`ALF_B_SEL1]};
					st_nxt.warn_latch_on = reg_wdata[`ALF_B_WLAT];
					st_nxt.critical_latch_on = reg_wdata[`ALF_B_CLAT];
				end
				default: begin
				end
			endcase
		end

		if (reg_rd) begin
			st_nxt.rvalid = 1'b1;
			case (reg_addr)
				`ALF_A_BUS3: st_nxt.rdata = st_r.bus[2];
				`ALF_A_CRIT1: st_nxt.rdata = st_r.crit_lim[0];
				`ALF_A_WARN1: st_nxt.rdata = st_r.warn_lim[0];
				`ALF_A_CRIT2: st_nxt.rdata = st_r.crit_lim[1];
				`ALF_A_WARN2: st_nxt.rdata = st_r.warn_lim[1];
				`ALF_A_CRIT3: st_nxt.rdata = st_r.crit_lim[2];
				`ALF_A_WARN3: st_nxt.rdata = st_r.warn_lim[2];
				`ALF_A_TOTAL: st_nxt.rdata = st_r.total;
				`ALF_A_TLIM: st_nxt.rdata = st_r.total_lim;
				`ALF_A_MASK: st_nxt.rdata = {1'b0, st_r.sum_channel_select[0],
					st_r.sum_channel_select[1], st_r.sum_channel_select[2],
					st_r.warn_latch_on, st_r.critical_latch_on,
					st_r.critical_flags[0], st_r.critical_flags[1], st_r.critical_flags[2],
					st_r.sum_over_flag,
					st_r.warning_flags[0], st_r.warning_flags[1], st_r.warning_flags[2],
					st_r.pv_pin, st_r.timing_alert_flag, st_r.conversion_done_flag};
				default: st_nxt.rdata = 16'h0000;
			endcase
		end

		// A read clears the flags, but an event in the same cycle still lands.
		if (mask_rd) begin
			st_nxt.critical_flags = '0;
			st_nxt.sum_over_flag = 1'b0;
			st_nxt.warning_flags = '0;
			st_nxt.conversion_done_flag = 1'b0;
		end
		if (cfg_write_clear) begin
			st_nxt.conversion_done_flag = 1'b0;
		end
		if (conv_done) begin
			st_nxt.conversion_done_flag = 1'b1;
		end

		if (bus_sample.valid && bus_sample.ch < 2'(`ALF_NCH)) begin
			st_nxt.bus[bus_sample.ch] = bus_sample.value & `ALF_LIM_MASK;
		end

		if (s_ok) begin
			st_nxt.crit_cond[shunt_single.ch] = s_exc;
			if (s_exc) begin
				st_nxt.critical_flags[shunt_single.ch] = 1'b1;
			end
		end
		if (a_ok) begin
			st_nxt.warn_cond[shunt_avg.ch] = a_exc;
			if (a_exc) begin
				st_nxt.warning_flags[shunt_avg.ch] = 1'b1;
			end
		end

		if (pass_done) begin
			st_nxt.total = {acc_in, 1'b0};
			st_nxt.acc = '0;
			st_nxt.sum_cond = sum_exc;
			if (sum_exc) begin
				st_nxt.sum_over_flag = 1'b1;
			end
		end else begin
			st_nxt.acc = acc_in;
		end

		// Hysteresis: set above the upper limit on all channels, drop when any channel is below lower.
		if (&pv_above) begin
			st_nxt.pv_pin = 1'b1;
		end else if (|pv_below) begin
			st_nxt.pv_pin = 1'b0;
		end

		// Hold tracks always, so turning the latch on never misses a past event.
		crit_any = (|st_nxt.crit_cond) | st_nxt.sum_cond;
		warn_any = |st_nxt.warn_cond;
		st_nxt.crit_hold = crit_any | (st_r.crit_hold & ~mask_rd);
		st_nxt.warn_hold = warn_any | (st_r.warn_hold & ~mask_rd);
		st_nxt.crit_pin_n = ~(st_r.critical_latch_on ? st_nxt.crit_hold : crit_any);
		st_nxt.warn_pin_n = ~(st_r.warn_latch_on ? st_nxt.warn_hold : warn_any);

		st_nxt.timing_alert_flag = st_r.timing_alert_flag | timing_alert_in;

		if (soft_reset) begin
			st_nxt = por_st();
			st_nxt.timing_alert_flag = timing_alert_in;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= por_st();
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign reg_rvalid = st_r.rvalid;
	assign crit_alert_n = st_r.crit_pin_n;
	assign warn_alert_n = st_r.warn_pin_n;
	assign power_valid_alert = st_r.pv_pin;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	logic quiet;
	assign quiet = !shunt_single.valid && !shunt_avg.valid && !pass_done && !soft_reset;

	sequence s_crit_hit;
		s_ok && s_exc && !soft_reset;
	endsequence

	property p_bus3_read;
		reg_rd && reg_addr == `ALF_A_BUS3 |=> reg_rvalid && reg_rdata == $past(st_r.bus[2])
			&& reg_rdata[2:0] == 3'h0;
	endproperty
	a_bus3_read: assert property (p_bus3_read) else $error("bus word read wrong");

	property p_crit_hit;
		s_crit_hit |=> !crit_alert_n ##0 (|st_r.critical_flags);
	endproperty
	a_crit_hit: assert property (p_crit_hit) else $error("critical hit missed");

	property p_warn_hit;
		a_ok && a_exc && !soft_reset |=> !warn_alert_n && (|st_r.warning_flags);
	endproperty
	a_warn_hit: assert property (p_warn_hit) else $error("warning hit missed");

	property p_lim_low;
		st_r.crit_lim[0][2:0] == 3'h0 && st_r.warn_lim[2][2:0] == 3'h0;
	endproperty
	a_lim_low: assert property (p_lim_low) else $error("limit low bits set");

	property p_unselected;
		s_ok && !st_r.sum_channel_select[shunt_single.ch] && !pass_done && !soft_reset
			|=> st_r.acc == $past(st_r.acc);
	endproperty
	a_unselected: assert property (p_unselected) else $error("unselected summed");

	property p_sum_flag;
		pass_done && sum_exc && !soft_reset |=> st_r.sum_over_flag && !crit_alert_n
			&& st_r.total[0] == 1'b0;
	endproperty
	a_sum_flag: assert property (p_sum_flag) else $error("sum alert missed");

	property p_read_clears;
		mask_rd && quiet |=> st_r.critical_flags == '0 && st_r.warning_flags == '0
			&& !st_r.sum_over_flag;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("flags not cleared");

	property p_write_keeps;
		mask_wr && !reg_rd && quiet |=> st_r.critical_flags == $past(st_r.critical_flags)
			&& st_r.warning_flags == $past(st_r.warning_flags);
	endproperty
	a_write_keeps: assert property (p_write_keeps) else $error("write moved flags");

	property p_crit_latched;
		st_r.critical_latch_on && !crit_alert_n && !mask_rd && !mask_wr && !soft_reset
			##1 !mask_rd && !soft_reset |=> !crit_alert_n;
	endproperty
	a_crit_latched: assert property (p_crit_latched) else $error("latch dropped");

	property p_warn_transparent;
		!st_r.warn_latch_on && !soft_reset |=> warn_alert_n == !(|st_r.warn_cond);
	endproperty
	a_warn_transparent: assert property (p_warn_transparent) else $error("warn not transparent");

	property p_pv_set;
		(&pv_above) && !soft_reset |=> power_valid_alert;
	endproperty
	a_pv_set: assert property (p_pv_set) else $error("power valid missed");

	property p_tc_sticky;
		st_r.timing_alert_flag && !soft_reset |=> st_r.timing_alert_flag;
	endproperty
	a_tc_sticky: assert property (p_tc_sticky) else $error("timing flag dropped");

	property p_cvr_set;
		conv_done && !soft_reset |=> st_r.conversion_done_flag;
	endproperty
	a_cvr_set: assert property (p_cvr_set) else $error("conversion flag missed");

endmodule

// ---- verif/alf_host_model.sv ----
// Purpose: Register host standing in for the serial bus master.
// Assumes: One-cycle read and write strobes; read answer one cycle later.
// Notes: Released write data shows the inverse so stale data never looks valid.
`timescale 1ns/1ps

module alf_host_model (
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
	end

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		ok = reg_rvalid;
		d = reg_rdata;
	endtask

	// Pending flags are drained first so each one belongs to the old setting.
	task automatic set_mode(input logic [15:0] d);
		logic [15:0] x;
		logic ok;
		rd(8'h0F, x, ok);
		wr(8'h0F, d);
	endtask
endmodule

// ---- verif/alert_limit_flag_logic_tb.sv ----
// Purpose: Self-checking bench of the alert limit flag logic.
// Assumes: Register host model drives the register strobes.
// Notes: Random values come from a fixed xorshift seed.
`timescale 1ns/1ps

module alert_limit_flag_logic_tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic soft_reset = 1'b0;
	logic pass_done = 1'b0;
	logic conv_done = 1'b0;
	logic cfg_write_clear = 1'b0;
	logic timing_alert_in = 1'b0;
	logic [15:0] pv_upper_limit = 16'h1000;
	logic [15:0] pv_lower_limit = 16'h0800;
	alf_pkg::alf_sample_t shunt_single = '0;
	alf_pkg::alf_sample_t shunt_avg = '0;
	alf_pkg::alf_sample_t bus_sample = '0;
	logic [7:0] reg_addr;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic reg_rvalid;
	logic crit_alert_n;
	logic warn_alert_n;
	logic power_valid_alert;
	int failures = 0;
	int n_compared = 0;
	logic [31:0] seed = 32'h0AF69639;
	logic [31:0] r;
	logic [15:0] v;
	logic [15:0] lim;
	logic [15:0] md;
	logic [14:0] acc;

	always #2.5 clk = ~clk;

	alf_alert_limit_flag alf_alert_limit_flag_inst (.clk(clk), .reset_n(reset_n),
		.soft_reset(soft_reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.shunt_single(shunt_single), .shunt_avg(shunt_avg), .bus_sample(bus_sample),
		.pass_done(pass_done), .conv_done(conv_done), .cfg_write_clear(cfg_write_clear),
		.timing_alert_in(timing_alert_in), .pv_upper_limit(pv_upper_limit),
		.pv_lower_limit(pv_lower_limit), .crit_alert_n(crit_alert_n),
		.warn_alert_n(warn_alert_n), .power_valid_alert(power_valid_alert));

	alf_host_model alf_host_model_inst (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [14:0] sx(input logic [15:0] x);
		return {{2{x[15]}}, x[15:3]};
	endfunction

	function automatic logic [15:0] pin(input int i);
		return {15'h0000, (i != 0) ? warn_alert_n : crit_alert_n};
	endfunction

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] d;
		logic ok;
		alf_host_model_inst.rd(a, d, ok);
		chk("rvalid", {15'h0000, ok}, 16'h0001);
		chk($sformatf("reg %h", a), d, exp);
	endtask

	task automatic check_por(input logic [15:0] mk);
		for (int a = 5; a < 17; a++) begin
			if (a != 15) begin
				rchk(a[7:0], (a == 14) ? 16'h7FFE : (a > 6 && a < 13) ? 16'h7FF8 : 16'h0000);
			end
		end
		rchk(8'h0F, mk);
	endtask

	task automatic smp(input int k, input logic [1:0] ch, input logic [15:0] x);
		@(posedge clk);
		#1;
		if (k == 0) shunt_single = '{1'b1, ch, x};
		else if (k == 1) shunt_avg = '{1'b1, ch, x};
		else bus_sample = '{1'b1, ch, x};
		@(posedge clk);
		#1;
		shunt_single.valid = 1'b0;
		shunt_avg.valid = 1'b0;
		bus_sample.valid = 1'b0;
	endtask

	task automatic pls(ref logic s);
		@(posedge clk);
		#1;
		s = 1'b1;
		@(posedge clk);
		#1;
		s = 1'b0;
	endtask

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// A hang costs one mismatch and still reaches the verdict.
	initial begin
		#400000;
		failures++;
		tally_and_finish();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		#1;
		reset_n = 1'b1;
		alf_host_model_inst.wr(8'h06, 16'hFFFF);
		alf_host_model_inst.wr(8'h0D, 16'hFFFF);
		check_por(16'h0002);
		$display("test reset values done");
		for (int a = 7; a < 15; a++) begin
			v = rnd();
			alf_host_model_inst.wr(a[7:0], v);
			rchk(a[7:0], (a == 13) ? 16'h0000 : v & ((a == 14) ? 16'hFFFE : 16'hFFF8));
			alf_host_model_inst.wr(a[7:0], 16'h7FFE);
		end
		$display("test limit access done");
		for (int k = 0; k < 2; k++) begin
			for (int c = 0; c < 3; c++) begin
				lim = (c == 2) ? 16'hF000 : 16'h1000;
				alf_host_model_inst.wr(8'h07 + 8'(2 * c + k), lim);
				smp(k, c[1:0], lim + 16'h0008);
				chk("pin set", pin(k), 16'h0000);
				smp(k, c[1:0], lim);
				chk("pin follows", pin(k), 16'h0001);
				rchk(8'h0F, 16'h0002 | (16'h0001 << ((k != 0) ? 5 - c : 9 - c)));
				rchk(8'h0F, 16'h0002);
				alf_host_model_inst.wr(8'h07 + 8'(2 * c + k), 16'h7FF8);
			end
		end
		$display("test transparent alerts done");
		for (int i = 0; i < 2; i++) begin
			md = (i != 0) ? 16'h0800 : 16'h0400;
			alf_host_model_inst.set_mode(md);
			alf_host_model_inst.wr(8'h09 + 8'(i), 16'h1000);
			smp(i, 2'd1, 16'h1008);
			chk("latched set", pin(i), 16'h0000);
			smp(i, 2'd1, 16'h0000);
			chk("latched hold", pin(i), 16'h0000);
			rchk(8'h0F, md | 16'h0002 | ((i != 0) ? 16'h0010 : 16'h0100));
			@(posedge clk);
			#1;
			chk("latched release", pin(i), 16'h0001);
			alf_host_model_inst.wr(8'h09 + 8'(i), 16'h7FF8);
		end
		$display("test latched alerts done");
		for (int n = 0; n < 12; n++) begin
			r = rnd();
			md = {1'b0, r[2:0], 12'h000};
			alf_host_model_inst.set_mode(md);
			lim = (rnd() & 16'h07FE) - 16'h0400;
			alf_host_model_inst.wr(8'h0E, lim);
			acc = '0;
			for (int c = 0; c < 3; c++) begin
				v = rnd() & 16'h0FF8;
				if (v[4]) v = -v;
				smp(0, c[1:0], v);
				if (md[14 - c]) acc += sx(v);
			end
			pls(pass_done);
			r[0] = $signed({acc, 1'b0}) > $signed(lim);
			chk("sum pin", pin(0), {15'h0000, ~r[0]});
			rchk(8'h0D, {acc, 1'b0});
			rchk(8'h0F, md | 16'h0002 | {9'h000, r[0], 6'h00});
		end
		$display("test shunt sum done");
		for (int c = 0; c < 3; c++) begin
			chk("pv low", {15'h0000, power_valid_alert}, 16'h0000);
			v = 16'h2000 | (rnd() & 16'h0FFF);
			smp(2, c[1:0], v);
		end
		// The pin follows the stored bus words one cycle after they land.
		@(posedge clk);
		#1;
		chk("pv high", {15'h0000, power_valid_alert}, 16'h0001);
		rchk(8'h06, v & 16'hFFF8);
		rchk(8'h0F, md | 16'h0006);
		smp(2, 2'd0, 16'h0000);
		@(posedge clk);
		#1;
		chk("pv drop", {15'h0000, power_valid_alert}, 16'h0000);
		rchk(8'h0F, md | 16'h0002);
		$display("test power valid done");
		pls(conv_done);
		rchk(8'h0F, md | 16'h0003);
		rchk(8'h0F, md | 16'h0002);
		pls(conv_done);
		pls(cfg_write_clear);
		rchk(8'h0F, md | 16'h0002);
		$display("test conversion flag done");
		pls(soft_reset);
		check_por(16'h0000);
		pls(timing_alert_in);
		rchk(8'h0F, 16'h0002);
		rchk(8'h0F, 16'h0002);
		$display("test timing flag done");
		tally_and_finish();
	end
endmodule
